// ===== psw_regs.vh
// Purpose: constants of the pll reference clock switchover block
// Assumes: included by psw_top.v and psw_clk_sense.v
// Notes:   definitions only
//
// Behaviour
// - automatic switch on falling edge of available input
// - gate at current fall, swap at new fall
// - override mode: indicator follows request level
// - manual switch keeps both lost flags low
// - only request rising edge starts a switch
// - wait until the target input toggles
// - primary input selected after reset
// - request high three cycles starts switch
// - stopped input: flag lost, select backup
// - both inputs stopped: no switch at all
// - lost flags undefined beyond 20% mismatch
`ifndef PSW_REGS_VH
`define PSW_REGS_VH

// ****************************************************
// register map
// ****************************************************
`define PSW_ADDR_CTRL      8'h00
`define PSW_ADDR_STATUS    8'h04
`define PSW_CTRL_RESET     2'h0
`define PSW_MODE_AUTO      2'h0
`define PSW_MODE_MANUAL    2'h1
`define PSW_MODE_OVERRIDE  2'h2

// ****************************************************
// status fields
// ****************************************************
`define PSW_ST_ACTIVE      0
`define PSW_ST_LOST0       1
`define PSW_ST_LOST1       2
`define PSW_ST_BUSY        3
`define PSW_ST_SEL         4

// ****************************************************
// timing
// ****************************************************
`define PSW_REQ_MIN_CYC    2'h3
`define PSW_LOSS_CYC       16
`define PSW_CNT_W          8

// ****************************************************
// switchover states
// ****************************************************
`define PSW_ST_IDLE        2'h0
`define PSW_ST_GATE        2'h1
`define PSW_ST_SWAP        2'h2

`endif

// ===== psw_clk_sense.v
// Purpose: samples one reference clock, reports edges and loss
// Assumes: reference much slower than clock_i
// Notes:   three flops, a change counts once flops two and three agree
`include "psw_regs.vh"
`default_nettype none

module psw_clk_sense #(
   parameter LOSS_CYC = `PSW_LOSS_CYC
) (
   // clock and reset
   input  wire clock_i,
   input  wire rst_n_i,
   // reference pin
   input  wire ref_i,
   // sampled view
   output wire level_o,
   output wire rise_o,
   output wire fall_o,
   output wire lost_o
);

   reg                   sync1_ff;
   reg                   sync2_ff;
   reg                   sync3_ff;
   reg                   level_ff;
   reg                   rise_ff;
   reg                   fall_ff;
   reg [`PSW_CNT_W-1:0]  idle_cnt_ff;
   reg                   lost_ff;
   wire                  agree;
   wire                  change;

   assign agree  = (sync2_ff == sync3_ff);
   assign change = agree && (sync3_ff != level_ff);

   // ****************************************************
   // sampling and loss sense
   // ****************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_ff    <= 1'b0;
         sync2_ff    <= 1'b0;
         sync3_ff    <= 1'b0;
         level_ff    <= 1'b0;
         rise_ff     <= 1'b0;
         fall_ff     <= 1'b0;
         idle_cnt_ff <= {`PSW_CNT_W{1'b0}};
         lost_ff     <= 1'b0;
      end else begin
         sync1_ff <= ref_i;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         rise_ff  <= change && sync3_ff;
         fall_ff  <= change && !sync3_ff;
         if (change) begin
            level_ff    <= sync3_ff;
            idle_cnt_ff <= {`PSW_CNT_W{1'b0}};
            lost_ff     <= 1'b0;
         end else if (idle_cnt_ff == LOSS_CYC[`PSW_CNT_W-1:0]) begin
            lost_ff     <= 1'b1;
         end else begin
            idle_cnt_ff <= idle_cnt_ff + {{(`PSW_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign level_o = level_ff;
   assign rise_o  = rise_ff;
   assign fall_o  = fall_ff;
   assign lost_o  = lost_ff;

endmodule // psw_clk_sense

`default_nettype wire

// ===== psw_top.v
// Purpose: glitch-free switchover between two pll reference clocks
// Assumes: single 100 MHz clock_i, references sampled as pins
// Notes:   ahb-lite slave, zero wait states, always OKAY
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`include "psw_regs.vh"
`default_nettype none

module psw_top #(
   parameter LOSS_CYC = `PSW_LOSS_CYC
) (
   // clock and reset
   input  wire        clock_i,
   input  wire        rst_n_i,
   // ahb-lite slave
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output wire [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   // reference clocks and fabric control
   input  wire        ref_clock_primary_i,
   input  wire        ref_clock_backup_i,
   input  wire        switch_request_i,
   // switchover outputs
   output wire        ref_clock_out_o,
   output wire        active_clock_o,
   output wire [1:0]  clock_lost_o
);

   // ****************************************************
   // reference sensing
   // ****************************************************
   wire       lvl0;
   wire       rise0;
   wire       fall0;
   wire       lost0;
   wire       lvl1;
   wire       rise1;
   wire       fall1;
   wire       lost1;

   psw_clk_sense #(.LOSS_CYC(LOSS_CYC)) u_sense0 (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .ref_i   (ref_clock_primary_i),
      .level_o (lvl0),
      .rise_o  (rise0),
      .fall_o  (fall0),
      .lost_o  (lost0)
   );

   psw_clk_sense #(.LOSS_CYC(LOSS_CYC)) u_sense1 (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .ref_i   (ref_clock_backup_i),
      .level_o (lvl1),
      .rise_o  (rise1),
      .fall_o  (fall1),
      .lost_o  (lost1)
   );

   // ****************************************************
   // registers and state
   // ****************************************************
   reg [1:0]  mode_ff;
   reg        addr_ok_ff;
   reg        wr_ff;
   reg [7:0]  addr_ff;
   reg [31:0] rdata_ff;
   reg        req1_ff;
   reg        req2_ff;
   reg        req3_ff;
   reg        req_lvl_ff;
   reg        armed_ff;
   reg [1:0]  req_cnt_ff;
   reg [1:0]  state_ff;
   reg        sel_ff;
   reg        out_ff;
   reg [1:0]  lost_ff;

   wire       cur_rise;
   wire       cur_fall;
   wire       cur_lost;
   wire       oth_fall;
   wire       oth_lost;
   wire       req_rise;
   wire       manual_go;
   wire       auto_go;
   wire       manual_en;
   wire       auto_en;
   wire       override;
   wire [31:0] status;
   wire       ahb_take;

   assign cur_rise = sel_ff ? rise1 : rise0;
   assign cur_fall = sel_ff ? fall1 : fall0;
   assign cur_lost = sel_ff ? lost1 : lost0;
   assign oth_fall = sel_ff ? fall0 : fall1;
   assign oth_lost = sel_ff ? lost0 : lost1;

   assign manual_en = (mode_ff == `PSW_MODE_MANUAL) || (mode_ff == `PSW_MODE_OVERRIDE);
   assign auto_en   = (mode_ff == `PSW_MODE_AUTO) || (mode_ff == `PSW_MODE_OVERRIDE);
   assign override  = (mode_ff == `PSW_MODE_OVERRIDE) && req_lvl_ff;

   // ****************************************************
   // switch request: sync, edge and high-time check
   // ****************************************************
   // edge seen only on the agreed level, so no metastable glitch arms it
   assign req_rise  = (req2_ff == req3_ff) && req3_ff && !req_lvl_ff;
   // third current-input cycle with request still high fires once
   assign manual_go = manual_en && armed_ff && req_lvl_ff && cur_rise &&
                      (req_cnt_ff == `PSW_REQ_MIN_CYC - 2'h1);
   // both stopped means nowhere to go, so stay put
   assign auto_go   = auto_en && !override && cur_lost && !oth_lost;

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req1_ff    <= 1'b0;
         req2_ff    <= 1'b0;
         req3_ff    <= 1'b0;
         req_lvl_ff <= 1'b0;
         armed_ff   <= 1'b0;
         req_cnt_ff <= 2'h0;
      end else begin
         req1_ff <= switch_request_i;
         req2_ff <= req1_ff;
         req3_ff <= req2_ff;
         if (req2_ff == req3_ff)
            req_lvl_ff <= req3_ff;
         if (req_rise) begin
            armed_ff   <= 1'b1;
            req_cnt_ff <= 2'h0;
         end else if (!req_lvl_ff || manual_go) begin
            // falling edge only disarms, never switches back
            armed_ff   <= 1'b0;
            req_cnt_ff <= 2'h0;
         end else if (armed_ff && cur_rise) begin
            req_cnt_ff <= req_cnt_ff + 2'h1;
         end
      end
   end

   // ****************************************************
   // switchover state machine and clock mux
   // ****************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= `PSW_ST_IDLE;
         sel_ff   <= 1'b0;
         out_ff   <= 1'b0;
         lost_ff  <= 2'h0;
      end else begin
         case (state_ff)
            `PSW_ST_IDLE: begin
               if (manual_go)
                  state_ff <= `PSW_ST_GATE;
               else if (auto_go)
                  state_ff <= `PSW_ST_SWAP;
            end
            `PSW_ST_GATE: begin
               // dead current input cannot give a fall edge
               if (cur_fall || cur_lost)
                  state_ff <= `PSW_ST_SWAP;
            end
            `PSW_ST_SWAP: begin
               // target not toggling: just keep waiting
               if (oth_fall) begin
                  state_ff <= `PSW_ST_IDLE;
                  sel_ff   <= !sel_ff;
               end
            end
            default: state_ff <= `PSW_ST_IDLE;
         endcase
         // output held low from current fall until new fall
         if (state_ff == `PSW_ST_SWAP)
            out_ff <= 1'b0;
         else
            out_ff <= sel_ff ? lvl1 : lvl0;
         // flags mean nothing when both stop or rates differ widely
         lost_ff <= (lost0 && lost1) ? lost_ff : {lost1, lost0};
      end
   end

   assign ref_clock_out_o = out_ff;
   assign active_clock_o  = (mode_ff == `PSW_MODE_OVERRIDE) ? req_lvl_ff : sel_ff;
   assign clock_lost_o    = lost_ff;

   // ****************************************************
   // ahb-lite slave
   // ****************************************************
   assign status = {27'h0, sel_ff, (state_ff != `PSW_ST_IDLE), lost_ff, active_clock_o};
   assign ahb_take = hsel_i && htrans_i[1] && hready_i;

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_ff    <= `PSW_CTRL_RESET;
         addr_ok_ff <= 1'b0;
         wr_ff      <= 1'b0;
         addr_ff    <= 8'h00;
         rdata_ff   <= 32'h0;
      end else begin
         addr_ok_ff <= ahb_take && (haddr_i[31:8] == 24'h0);
         wr_ff      <= ahb_take && hwrite_i;
         addr_ff    <= haddr_i[7:0];
         rdata_ff   <= 32'h0;
         // read data captured at address phase, unmapped reads zero
         if (ahb_take && !hwrite_i && (haddr_i[31:8] == 24'h0)) begin
            if (haddr_i[7:0] == `PSW_ADDR_CTRL)
               rdata_ff <= {30'h0, mode_ff};
            else if (haddr_i[7:0] == `PSW_ADDR_STATUS)
               rdata_ff <= status;
         end
         if (addr_ok_ff && wr_ff && (addr_ff == `PSW_ADDR_CTRL) && (hwdata_i[1:0] != 2'h3))
            mode_ff <= hwdata_i[1:0];
      end
   end

   assign hrdata_o    = rdata_ff;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

endmodule // psw_top

`default_nettype wire

// ===== psw_top_sva.sv
// Purpose: port-level assertions for psw_top
// Assumes: one clock, zero-wait bus
// Notes:   mode copied from bus writes, pin-still counters
`default_nettype none
module psw_top_sva #(
   parameter int LOSS_CYC = 16
) (
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic        ref_clock_primary_i,
   input wire logic        ref_clock_backup_i,
   input wire logic        switch_request_i,
   input wire logic        ref_clock_out_o,
   input wire logic        active_clock_o,
   input wire logic [1:0]  clock_lost_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] mode_ff;
   logic       wph_ff;
   logic       pd_ff;
   logic       bd_ff;
   logic [7:0] ps_ff;
   logic [7:0] bs_ff;
   logic [7:0] lo_ff;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // ****
   // helpers
   // ****
   // counters saturate so a long stop never wraps to zero
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_ff <= 2'h0;
         wph_ff  <= 1'b0;
         pd_ff   <= 1'b0;
         bd_ff   <= 1'b0;
         ps_ff   <= 8'h0;
         bs_ff   <= 8'h0;
         lo_ff   <= 8'h0;
      end else begin
         if (hready_i) wph_ff <= hsel_i & htrans_i[1] & hwrite_i & (haddr_i == 32'h0);
         if (hready_i && wph_ff && hwdata_i[1:0] != 2'h3) mode_ff <= hwdata_i[1:0];
         pd_ff <= ref_clock_primary_i;
         bd_ff <= ref_clock_backup_i;
         ps_ff <= (pd_ff != ref_clock_primary_i) ? 8'h0 : ps_ff + {7'h0, ~&ps_ff};
         bs_ff <= (bd_ff != ref_clock_backup_i) ? 8'h0 : bs_ff + {7'h0, ~&bs_ff};
         lo_ff <= switch_request_i ? 8'h0 : lo_ff + {7'h0, ~&lo_ff};
      end
   end
   // ****
   // assertions
   // ****
   a_reset_primary: assert property ($rose(rst_n_i) |-> !active_clock_o)
      else $error("primary not selected after reset");
   a_override_high: assert property ((mode_ff == 2'h2 && switch_request_i) [*8] |-> active_clock_o)
      else $error("indicator not following high request");
   a_override_low: assert property ((mode_ff == 2'h2 && !switch_request_i) [*8] |-> !active_clock_o)
      else $error("indicator not following low request");
   a_gate_before_swap: assert property (mode_ff != 2'h2 && $changed(active_clock_o) |-> !$past(ref_clock_out_o))
      else $error("selection changed while reference not gated");
   a_manual_held: assert property (mode_ff == 2'h1 && $changed(active_clock_o) |-> $past(switch_request_i, 16))
      else $error("manual switch without held request");
   a_fall_no_return: assert property (mode_ff == 2'h1 && lo_ff > 8'd80 |-> $stable(active_clock_o))
      else $error("selection moved with request low");
   a_manual_no_lost: assert property (mode_ff == 2'h1 && $changed(active_clock_o) |-> clock_lost_o == 2'h0)
      else $error("lost flag during manual switch");
   a_lost_sets: assert property (ps_ff > LOSS_CYC + 8 && bs_ff < LOSS_CYC |-> ##[0:8] clock_lost_o[0])
      else $error("stopped primary not flagged");
   a_lost_clears: assert property (ps_ff == 8'd8 |-> !clock_lost_o[0])
      else $error("primary flag set early or stuck");
   a_auto_to_backup: assert property (mode_ff == 2'h0 && clock_lost_o == 2'h1 && !active_clock_o && bs_ff < 8'd8
      |-> ##[1:60] active_clock_o)
      else $error("no switch to running backup");
   a_both_dead_hold: assert property (mode_ff != 2'h2 && ps_ff > 8'd40 && bs_ff > 8'd40 |=> $stable(active_clock_o))
      else $error("switched with both inputs stopped");
   c_manual_swap: cover property (mode_ff == 2'h1 && $changed(active_clock_o));
   c_auto_swap: cover property (mode_ff == 2'h0 && $rose(active_clock_o));
   c_both_dead: cover property (ps_ff > 8'd40 && bs_ff > 8'd40);
endmodule // psw_top_sva
bind psw_top psw_top_sva #(.LOSS_CYC(LOSS_CYC)) u_sva (
   .clock_i             (clock_i),
   .rst_n_i             (rst_n_i),
   .hsel_i              (hsel_i),
   .haddr_i             (haddr_i),
   .htrans_i            (htrans_i),
   .hwrite_i            (hwrite_i),
   .hwdata_i            (hwdata_i),
   .hready_i            (hready_i),
   .ref_clock_primary_i (ref_clock_primary_i),
   .ref_clock_backup_i  (ref_clock_backup_i),
   .switch_request_i    (switch_request_i),
   .ref_clock_out_o     (ref_clock_out_o),
   .active_clock_o      (active_clock_o),
   .clock_lost_o        (clock_lost_o)
);
`default_nettype wire

// ===== psw_fabric_model.sv
// Purpose: fabric side, reference clocks and switch request
// Assumes: bench calls drive_req right after a clock_i edge
// Notes:   a stopped reference rests low like a dead oscillator
`default_nettype none
module psw_fabric_model #(
   parameter int HALF_P_NS = 50,
   parameter int HALF_B_NS = 56
) (
   input  wire logic clock_i,
   input  wire logic run_primary_i,
   input  wire logic run_backup_i,
   input  wire logic [1:0] clock_lost_i,
   output var  logic ref_clock_primary_o,
   output var  logic ref_clock_backup_o,
   output var  logic switch_request_o,
   output var  logic phase_detector_enable_o,
   output var  logic clock_net_enable_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ref_clock_primary_o = 1'b0;
      ref_clock_backup_o  = 1'b0;
      switch_request_o    = 1'b0;
   end
   // periods 12% apart, even half period keeps edges off posedge
   always #(HALF_P_NS) ref_clock_primary_o <= run_primary_i & ~ref_clock_primary_o;
   always #(HALF_B_NS) ref_clock_backup_o <= run_backup_i & ~ref_clock_backup_o;
   // no lock output on the block, so a settle count stands in for stable lock
   int unsigned settle_cnt = 0;
   always_comb phase_detector_enable_o = ~|clock_lost_i;
   always @(posedge clock_i) settle_cnt <= (|clock_lost_i) ? 0 : settle_cnt + (settle_cnt < 32);
   always_comb clock_net_enable_o = (settle_cnt >= 32);
   task automatic drive_req(input logic lvl, input int cyc);
      @(posedge clock_i);
      switch_request_o <= lvl & run_primary_i & run_backup_i;
      repeat (cyc) @(posedge clock_i);
   endtask
endmodule // psw_fabric_model
`default_nettype wire

// ===== pll_ref_clock_switchover_tb.sv
// Purpose: self-checking bench for the reference switchover
// Assumes: zero-wait bus, references near clock_i / 11
// Notes:   default loss count kept, references slow enough
`include "psw_regs.vh"
`default_nettype none
module pll_ref_clock_switchover_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] A_CTRL = {24'h0, `PSW_ADDR_CTRL};
   localparam logic [31:0] A_STAT = {24'h0, `PSW_ADDR_STATUS};
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic        run_p   = 1'b1;
   logic        run_b   = 1'b1;
   logic [31:0] hrdata;
   logic [1:0]  lost;
   logic        hready, ref_p, ref_b, req, active;
   logic        hresp, ref_out, pde, net_en;
   int          fails = 0;
   int          n_compared = 0;
   wire logic [31:0] obs = {29'h0, lost, active};
   always #5 clock_i = ~clock_i;
   psw_fabric_model fab (.clock_i(clock_i), .run_primary_i(run_p), .run_backup_i(run_b), .clock_lost_i(lost),
      .ref_clock_primary_o(ref_p), .ref_clock_backup_o(ref_b), .switch_request_o(req),
      .phase_detector_enable_o(pde), .clock_net_enable_o(net_en));
   psw_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .ref_clock_primary_i(ref_p), .ref_clock_backup_i(ref_b),
      .switch_request_i(req), .ref_clock_out_o(ref_out), .active_clock_o(active), .clock_lost_o(lost));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // for reads d is the expected word
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge clock_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock_i); while (hready !== 1'b1);
      if (!wr) chk(hrdata, d);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic wait_obs(input logic [31:0] exp);
      for (int i = 0; i < 300 && obs !== exp; i++) @(posedge clock_i);
      chk(obs, exp);
   endtask
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic t_regs();
      bus(1'b0, A_CTRL, 32'h0);
      bus(1'b0, A_STAT, 32'h0);
      bus(1'b1, A_STAT, 32'h1f);
      bus(1'b1, 32'h8, 32'h1);
      bus(1'b0, 32'h8, 32'h0);
      bus(1'b0, A_STAT, 32'h0);
      bus(1'b1, A_CTRL, 32'h3);
      bus(1'b0, A_CTRL, 32'h0);
   endtask
   task automatic t_manual();
      bus(1'b1, A_CTRL, {30'h0, `PSW_MODE_MANUAL});
      bus(1'b0, A_CTRL, {30'h0, `PSW_MODE_MANUAL});
      fab.drive_req(1'b1, 90);
      chk(obs, 32'h1);
      bus(1'b0, A_STAT, 32'h11);
      for (int i = 0; i < 30 && ref_out !== 1'b1; i++) @(posedge clock_i);
      chk({31'h0, ref_out}, 32'h1);
      fab.drive_req(1'b0, 100);
      chk(obs, 32'h1);
      // pll reset after the switch, two cycles is well past the minimum
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      bus(1'b0, A_STAT, 32'h0);
      bus(1'b1, A_CTRL, {30'h0, `PSW_MODE_MANUAL});
      fab.drive_req(1'b1, 90);
      chk(obs, 32'h1);
      fab.drive_req(1'b0, 20);
      fab.drive_req(1'b1, 2);
      fab.drive_req(1'b0, 100);
      chk(obs, 32'h1);
   endtask
   task automatic t_override();
      bus(1'b1, A_CTRL, {30'h0, `PSW_MODE_OVERRIDE});
      fab.drive_req(1'b1, 90);
      chk(obs, 32'h1);
      fab.drive_req(1'b0, 20);
      chk(obs, 32'h0);
      bus(1'b0, A_STAT, 32'h0);
   endtask
   task automatic t_auto();
      bus(1'b1, A_CTRL, {30'h0, `PSW_MODE_AUTO});
      run_p <= 1'b0;
      wait_obs(32'h3);
      chk({30'h0, net_en, pde}, 32'h0);
      run_p <= 1'b1;
      wait_obs(32'h1);
      run_b <= 1'b0;
      wait_obs(32'h4);
      run_b <= 1'b1;
      wait_obs(32'h0);
      repeat (40) @(posedge clock_i);
      chk({30'h0, net_en, pde}, 32'h3);
      run_p <= 1'b0;
      run_b <= 1'b0;
      repeat (200) @(posedge clock_i);
      chk(obs & 32'h1, 32'h0);
      chk({31'h0, ref_out}, 32'h0);
      run_b <= 1'b1;
      wait_obs(32'h3);
   endtask
   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      t_regs();
      t_manual();
      t_override();
      t_auto();
      summarize();
   end
   // run needs about 1,000 cycles; fifteen times that before giving up
   initial begin
      #150000;
      fails++;
      summarize();
   end
endmodule // pll_ref_clock_switchover_tb
`default_nettype wire
